// *** lacr_pkg.sv ***
// constants, types and register map of the load-adaptive regulator
// Notes on behaviour
// - minimum select 0 sets the floor to half the scale, 1 to a quarter
// - decrement only after 32, 8, 2 or 1 samples at or above upper threshold
// - upper threshold is (lower + offset + 1) times 32
// - each sample below lower threshold raises the factor by 1, 2, 4 or 8
// - lower threshold field zero disables the regulation
// - nonzero lower field: increase when load is below field times 32
// - filter bit 0 uses raw load, 1 uses value updated every four full steps
// - stall threshold bits 14..8 are a signed value from -64 to +63
// - stall threshold sets readout range and stall indicator sensitivity
// - current scale field scales coil currents by (value + 1) / 32
// - current scale applies to both coils in serial and step/direction use
package lacr_pkg;
   // apb byte addresses
   localparam logic [7:0] ADDR_ADAPT = 8'h00;
   localparam logic [7:0] ADDR_STALL = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
   // load_adaptive_config field positions
   localparam int MIN_SEL_BIT = 15;
   localparam int DEC_CNT_LSB = 13;
   localparam int UP_OFS_LSB = 8;
   localparam int INC_STEP_LSB = 5;
   localparam int LOW_THR_LSB = 0;
   // stall_and_scale_config field positions
   localparam int FILT_BIT = 16;
   localparam int STALL_THR_LSB = 8;
   localparam int CUR_SCALE_LSB = 0;
   // writable bit masks, reserved and address bits read as zero
   localparam logic [19:0] ADAPT_MASK = 20'h0EF6F;
   localparam logic [19:0] STALL_MASK = 20'h17F1F;
   localparam logic [19:0] ADAPT_RESET = 20'h00000;
   localparam logic [19:0] STALL_RESET = 20'h0001F;
   // threshold step of the load value
   localparam int THR_UNIT = 32;
   localparam int LOAD_W = 10;
   localparam int NIRQ = 4;
   // interrupt bit positions
   localparam int IRQ_INC = 0;
   localparam int IRQ_DEC = 1;
   localparam int IRQ_AT_MIN = 2;
   localparam int IRQ_STALL = 3;

   // decoded adaptive configuration
   typedef struct packed {
      logic min_sel;
      logic [1:0] dec_cnt;
      logic [3:0] up_ofs;
      logic [1:0] inc_step;
      logic [3:0] low_thr;
   } lacr_adapt_s;

   // decoded stall and scale configuration
   typedef struct packed {
      logic filt_en;
      logic signed [6:0] stall_thr;
      logic [4:0] cur_scale;
   } lacr_stall_s;

   // regulator states
   typedef enum logic [2:0] {
      ST_OFF = 3'b001,
      ST_RUN = 3'b010,
      ST_SAT = 3'b100
   } lacr_state_e;
endpackage : lacr_pkg

// *** lacr_load_filter.sv ***
// load measurement filter: raw or averaged over four full steps
module lacr_load_filter #(
   parameter int LOAD_W = 10
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // control
   input wire logic filt_en,
   input wire logic full_step,
   // load samples
   input wire logic sample_vld,
   input wire logic [LOAD_W-1:0] load_in,
   // filtered output
   output logic out_vld,
   output logic [LOAD_W-1:0] load_out
);
   logic [LOAD_W+1:0] sum_q;
   logic [1:0] step_cnt_q;
   logic [LOAD_W-1:0] last_q;

   // keep the latest raw sample for the averaging window
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         last_q <= '0;
      else if (sample_vld)
         last_q <= load_in;
   end

   // one result per sample in raw mode, one per four full steps filtered
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sum_q <= '0;
         step_cnt_q <= 2'h0;
         out_vld <= 1'b0;
         load_out <= '0;
      end
      else
      begin
         out_vld <= 1'b0;
         if (!filt_en)
         begin
            step_cnt_q <= 2'h0;
            sum_q <= '0;
            if (sample_vld)
            begin
               out_vld <= 1'b1;
               load_out <= load_in;
            end
         end
         else if (full_step)
         begin
            step_cnt_q <= step_cnt_q + 2'h1;
            if (step_cnt_q == 2'h3)
            begin
               // averaging of four steps evens out motor construction spread
               load_out <= LOAD_W'((sum_q + (LOAD_W+2)'(last_q))
                                   >> 2);
               out_vld <= 1'b1;
               sum_q <= '0;
            end
            else
               sum_q <= sum_q + (LOAD_W+2)'(last_q);
         end
      end
   end
endmodule : lacr_load_filter

// *** lacr_regulator.sv ***
// load-adaptive coil current regulator with apb register access
//
// Our own choices: the APB slave port and the address map.
module lacr_regulator #(
   parameter int LOAD_W = 10
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // load measurement from the sensing logic
   input wire logic load_vld,
   input wire logic [LOAD_W-1:0] load_raw,
   input wire logic full_step,
   // coil current targets from the sequencer
   input wire logic [7:0] coil_a_in,
   input wire logic [7:0] coil_b_in,
   // outputs
   output logic [7:0] coil_a_out,
   output logic [7:0] coil_b_out,
   output logic [4:0] scale_factor,
   output logic [LOAD_W-1:0] load_readout,
   output logic stall_indicator_output,
   output logic irq
);
   logic [19:0] adapt_q;
   logic [19:0] stall_q;
   lacr_pkg::lacr_adapt_s acfg;
   lacr_pkg::lacr_stall_s scfg;
   logic [4:0] factor_q;
   logic [4:0] floor_v;
   logic [5:0] dec_seen_q;
   logic [5:0] dec_need;
   logic [3:0] inc_amt;
   logic [LOAD_W+1:0] low_lim;
   logic [LOAD_W+1:0] up_lim;
   logic [LOAD_W-1:0] fload;
   logic fvld;
   logic [LOAD_W+1:0] sload;
   logic [5:0] floor_w;
   logic [lacr_pkg::NIRQ-1:0] irq_stat_q;
   logic [lacr_pkg::NIRQ-1:0] irq_mask_q;
   logic [lacr_pkg::NIRQ-1:0] irq_ev;
   lacr_pkg::lacr_state_e state_q;
   logic wr_en;
   logic rd_acc;
   logic addr_ok;

   // scale a coil value by (factor + 1) / 32
   function automatic logic [7:0] scale_coil(input logic [7:0] v,
                                             input logic [4:0] f);
      logic [13:0] p;
      p = 14'(v) * (14'(f) + 14'h1);
      return p[12:5];
   endfunction : scale_coil

   assign acfg = lacr_pkg::lacr_adapt_s'({adapt_q[15:13], adapt_q[11:8],
                                           adapt_q[6:5], adapt_q[3:0]});
   assign scfg = lacr_pkg::lacr_stall_s'({stall_q[16], stall_q[14:8],
                                           stall_q[4:0]});

   // apb decode: single wait-free access, unmapped addresses error
   assign addr_ok = (paddr == lacr_pkg::ADDR_ADAPT) ||
                    (paddr == lacr_pkg::ADDR_STALL) ||
                    (paddr == lacr_pkg::ADDR_STATUS) ||
                    (paddr == lacr_pkg::ADDR_IRQ_STAT) ||
                    (paddr == lacr_pkg::ADDR_IRQ_MASK);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;
   assign wr_en = psel && penable && pwrite;
   assign rd_acc = psel && !penable && !pwrite;

   // configuration words, reserved bits forced to zero on write
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         adapt_q <= lacr_pkg::ADAPT_RESET;
         stall_q <= lacr_pkg::STALL_RESET;
      end
      else if (wr_en)
      begin
         if (paddr == lacr_pkg::ADDR_ADAPT)
            adapt_q <= pwdata[19:0] & lacr_pkg::ADAPT_MASK;
         if (paddr == lacr_pkg::ADDR_STALL)
            stall_q <= pwdata[19:0] & lacr_pkg::STALL_MASK;
      end
   end

   // mask register
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         irq_mask_q <= '0;
      else if (wr_en && paddr == lacr_pkg::ADDR_IRQ_MASK)
         irq_mask_q <= pwdata[lacr_pkg::NIRQ-1:0];
   end

   // sticky status, write one clears, a new event wins over the clear
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         irq_stat_q <= '0;
      else
      begin
         if (wr_en && paddr == lacr_pkg::ADDR_IRQ_STAT)
            irq_stat_q <= (irq_stat_q & ~pwdata[lacr_pkg::NIRQ-1:0]) | irq_ev;
         else
            irq_stat_q <= irq_stat_q | irq_ev;
      end
   end

   assign irq = |(irq_stat_q & irq_mask_q);

   // read data registered at setup so it is stable in the access phase
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         prdata <= 32'h00000000;
      else if (rd_acc)
      begin
         unique case (paddr)
            lacr_pkg::ADDR_ADAPT: prdata <= {12'h000, adapt_q};
            lacr_pkg::ADDR_STALL: prdata <= {12'h000, stall_q};
            lacr_pkg::ADDR_STATUS:
               prdata <= {9'h000, state_q, stall_indicator_output, 2'h0,
                          factor_q, 2'h0, 10'(load_readout)};
            lacr_pkg::ADDR_IRQ_STAT: prdata <= 32'(irq_stat_q);
            lacr_pkg::ADDR_IRQ_MASK: prdata <= 32'(irq_mask_q);
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   // load filter in front of the regulator
   lacr_load_filter #(.LOAD_W(LOAD_W)) u_filt (
      .clk(clk),
      .nrst(nrst),
      .filt_en(scfg.filt_en),
      .full_step(full_step),
      .sample_vld(load_vld),
      .load_in(load_raw),
      .out_vld(fvld),
      .load_out(fload)
   );

   // readout shifted by the signed stall threshold; higher threshold values read lower
   assign sload = (LOAD_W+2)'(fload) -
                  (LOAD_W+2)'({{(LOAD_W-5){scfg.stall_thr[6]}},
                               scfg.stall_thr});

   // readout and stall indicator; a stall is a clipped-to-zero reading
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         load_readout <= '0;
         stall_indicator_output <= 1'b0;
      end
      else if (fvld)
      begin
         if (sload[LOAD_W+1])
            load_readout <= '0;
         else if (sload[LOAD_W])
            load_readout <= '1;
         else
            load_readout <= sload[LOAD_W-1:0];
         stall_indicator_output <= sload[LOAD_W+1] ||
                                   (sload == '0);
      end
   end

   // thresholds and step sizes from the fields
   assign low_lim = (LOAD_W+2)'(acfg.low_thr) *
                    (LOAD_W+2)'(lacr_pkg::THR_UNIT);
   assign up_lim = ((LOAD_W+2)'(acfg.low_thr) + (LOAD_W+2)'(acfg.up_ofs) +
                    (LOAD_W+2)'(1)) *
                   (LOAD_W+2)'(lacr_pkg::THR_UNIT);
   // floor in factor units; tiny scales would wrap below zero, so clamp
   assign floor_w = acfg.min_sel
                    ? (6'(scfg.cur_scale) + 6'h01) >> 2
                    : (6'(scfg.cur_scale) + 6'h01) >> 1;
   assign floor_v = (floor_w == 6'h00) ? 5'h00 : 5'(floor_w - 6'h01);

   // decrement sample count and increment size decoding
   always_comb
   begin
      unique case (acfg.dec_cnt)
         2'h0: dec_need = 6'h20;
         2'h1: dec_need = 6'h08;
         2'h2: dec_need = 6'h02;
         2'h3: dec_need = 6'h01;
      endcase
      unique case (acfg.inc_step)
         2'h0: inc_amt = 4'h1;
         2'h1: inc_amt = 4'h2;
         2'h2: inc_amt = 4'h4;
         2'h3: inc_amt = 4'h8;
      endcase
   end

   // adaptive factor: steps only on filtered samples, saturating both ways
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         factor_q <= 5'h1F;
         dec_seen_q <= 6'h00;
         state_q <= lacr_pkg::ST_OFF;
         irq_ev <= '0;
      end
      else
      begin
         irq_ev <= '0;
         if (acfg.low_thr == 4'h0)
         begin
            // disabled: full programmed scale
            factor_q <= scfg.cur_scale;
            dec_seen_q <= 6'h00;
            state_q <= lacr_pkg::ST_OFF;
         end
         else if (state_q == lacr_pkg::ST_OFF)
         begin
            // enabling starts from the floor and climbs with load
            factor_q <= floor_v;
            state_q <= lacr_pkg::ST_RUN;
         end
         else if (factor_q > scfg.cur_scale)
            factor_q <= scfg.cur_scale;
         else if (factor_q < floor_v)
            factor_q <= floor_v;
         else if (fvld)
         begin
            // a negative reading is below any limit; unsigned compare misses it
            if (sload[LOAD_W+1] || sload < low_lim)
            begin
               dec_seen_q <= 6'h00;
               irq_ev[lacr_pkg::IRQ_INC] <= 1'b1;
               if (6'(factor_q) + 6'(inc_amt) >= 6'(scfg.cur_scale))
                  factor_q <= scfg.cur_scale;
               else
                  factor_q <= factor_q + 5'(inc_amt);
               state_q <= lacr_pkg::ST_RUN;
            end
            else if (sload >= up_lim)
            begin
               if (dec_seen_q + 6'h01 >= dec_need)
               begin
                  dec_seen_q <= 6'h00;
                  irq_ev[lacr_pkg::IRQ_DEC] <= 1'b1;
                  if (factor_q > floor_v)
                     factor_q <= factor_q - 5'h01;
                  else
                  begin
                     state_q <= lacr_pkg::ST_SAT;
                     irq_ev[lacr_pkg::IRQ_AT_MIN] <= 1'b1;
                  end
               end
               else
                  dec_seen_q <= dec_seen_q + 6'h01;
            end
            else
               dec_seen_q <= 6'h00;
         end
         if (fvld && sload[LOAD_W+1])
            irq_ev[lacr_pkg::IRQ_STALL] <= 1'b1;
      end
   end

   assign scale_factor = factor_q;

   // both coils scaled alike, whatever the step source
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         coil_a_out <= 8'h00;
         coil_b_out <= 8'h00;
      end
      else
      begin
         coil_a_out <= scale_coil(coil_a_in, factor_q);
         coil_b_out <= scale_coil(coil_b_in, factor_q);
      end
   end
endmodule : lacr_regulator

// *** lacr_regulator_sva.sv ***
// port checker for the load-adaptive regulator, bound to its top module
module lacr_chk #(
   parameter int LOAD_W = 10
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // coil path, factor and interrupt
   input wire logic [7:0] coil_a_in,
   input wire logic [7:0] coil_b_in,
   input wire logic [7:0] coil_a_out,
   input wire logic [7:0] coil_b_out,
   input wire logic [4:0] scale_factor,
   input wire logic irq
);
   logic wr;
   logic rd;
   logic hit;
   // writes may move the factor freely, so steps are judged away from them
   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign hit = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // coil reference, widened so the product cannot wrap
   function automatic logic [7:0] scl(logic [7:0] c, logic [4:0] f);
      return 8'((14'(c) * (14'(f) + 14'h1)) >> 5);
   endfunction : scl
   AST_ERR_UNMAPPED:
      assert property (psel && penable && !hit |-> pslverr)
      else $error("no error on unmapped access");
   AST_ERR_MAPPED:
      assert property (psel && penable && hit |-> !pslverr)
      else $error("error on mapped access");
   AST_RD_UNMAPPED:
      assert property (rd && !hit |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   AST_ADAPT_RSVD:
      assert property (rd && paddr == 8'h00
         |-> (prdata & ~{12'h000, lacr_pkg::ADAPT_MASK}) == 32'h0)
      else $error("adaptive reserved bits set");
   AST_STALL_RSVD:
      assert property (rd && paddr == 8'h04
         |-> (prdata & ~{12'h000, lacr_pkg::STALL_MASK}) == 32'h0)
      else $error("stall reserved bits set");
   AST_COIL_A:
      assert property (1'b1 |=> coil_a_out ==
         scl($past(coil_a_in), $past(scale_factor)))
      else $error("coil a scaling wrong");
   AST_COIL_B:
      assert property (1'b1 |=> coil_b_out ==
         scl($past(coil_b_in), $past(scale_factor)))
      else $error("coil b scaling wrong");
   AST_INC_STEP:
      assert property (!wr && !$past(wr) && !$past(wr, 2)
         |=> {1'b0, scale_factor} <= {1'b0, $past(scale_factor)} + 6'h08)
      else $error("factor rose by more than eight");
   AST_DEC_ONE:
      assert property (!wr && !$past(wr) && !$past(wr, 2)
         |=> {1'b0, scale_factor} + 6'h01 >= {1'b0, $past(scale_factor)})
      else $error("factor fell by more than one");
   cover property (wr && paddr == 8'h00);
   cover property (irq);
   cover property (scale_factor < $past(scale_factor));
endmodule : lacr_chk

bind lacr_regulator lacr_chk #(.LOAD_W(LOAD_W)) u_chk (
   .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
   .coil_a_in(coil_a_in), .coil_b_in(coil_b_in),
   .coil_a_out(coil_a_out), .coil_b_out(coil_b_out),
   .scale_factor(scale_factor), .irq(irq)
);

// *** lacr_load_src.sv ***
// load sensing model: load samples on request, free full step pulses
module lacr_load_src (
   // clock
   input wire logic clk,
   // samples towards the regulator
   output logic load_vld,
   output logic [9:0] load_raw,
   output logic full_step
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_q = 4'h0;
   initial
   begin
      load_vld = 1'b0;
      load_raw = 10'h2AA;
      full_step = 1'b0;
   end
   // one full step every sixteen cycles, only the filter looks at it
   always @(posedge clk)
   begin
      cnt_q <= cnt_q + 4'h1;
      full_step <= (cnt_q == 4'hF);
   end
   // one-cycle sample; the value is inverted afterwards so it never lingers
   task send(input logic [9:0] v);
      @(posedge clk);
      load_vld <= 1'b1;
      load_raw <= v;
      @(posedge clk);
      load_vld <= 1'b0;
      load_raw <= ~v;
   endtask : send
endmodule : lacr_load_src

// *** lacr_regulator_tb.sv ***
// self-checking bench for the load-adaptive regulator
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module lacr_regulator_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, coil_a_in = 8'h00, coil_b_in = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, load_vld, full_step, stall_out, irq;
   logic [9:0] load_raw, load_readout;
   logic [7:0] coil_a_out, coil_b_out;
   logic [4:0] scale_factor;
   int fails = 0;
   int samples_checked = 0;
   lacr_regulator #(.LOAD_W(10)) uut (
      .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .load_vld(load_vld),
      .load_raw(load_raw), .full_step(full_step), .coil_a_in(coil_a_in),
      .coil_b_in(coil_b_in), .coil_a_out(coil_a_out),
      .coil_b_out(coil_b_out), .scale_factor(scale_factor),
      .load_readout(load_readout), .stall_indicator_output(stall_out),
      .irq(irq));
   lacr_load_src u_src (.clk(clk), .load_vld(load_vld),
      .load_raw(load_raw), .full_step(full_step));
   // 200 MHz
   always #2.5 clk = ~clk;
   task end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   // one apb transfer; the request stands until pready is seen high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge clk);
         i++;
      end
      while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1)
      begin
         fails++;
         end_of_test;
      end
      else
      begin
         // answer taken at the edge pready was seen, only then released
         r = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      repeat (3) @(posedge clk);
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask : rd
   // load sample, then the fixed two-stage latency plus margin
   task smp(input logic [9:0] v);
      u_src.send(v);
      repeat (4) @(posedge clk);
   endtask : smp
   function automatic logic [31:0] adw(logic m, logic [1:0] dn,
      logic [3:0] ofs, logic [1:0] up, logic [3:0] lo);
      return {16'h0, m, dn, 1'b0, ofs, 1'b0, up, 1'b0, lo};
   endfunction : adw
   task t_regs;
      logic [31:0] r;
      logic e;
      `CHK(scale_factor, 5'h1F)
      rd(lacr_pkg::ADDR_ADAPT, r);
      `CHK(r, 32'h0)
      rd(lacr_pkg::ADDR_STALL, r);
      `CHK(r, 32'h0000001F)
      apb(1'b0, 8'h14, 32'h0, r, e);
      `CHK({e, r}, 33'h100000000)
      // only field bits are written, reserved bits stay zero
      wr(lacr_pkg::ADDR_ADAPT, 32'h0000EF6F);
      rd(lacr_pkg::ADDR_ADAPT, r);
      `CHK(r, 32'h0000EF6F)
      wr(lacr_pkg::ADDR_STALL, 32'h00017F1F);
      rd(lacr_pkg::ADDR_STALL, r);
      `CHK(r, 32'h00017F1F)
      apb(1'b1, 8'h14, 32'hFFFFFFFF, r, e);
      `CHK(e, 1'b1)
   endtask : t_regs
   task t_coil;
      wr(lacr_pkg::ADDR_ADAPT, 32'h0);
      wr(lacr_pkg::ADDR_STALL, 32'h00000014);
      coil_a_in <= 8'hFF;
      coil_b_in <= 8'h40;
      smp(10'h000);
      `CHK(scale_factor, 5'h14)
      `CHK(coil_a_out, 8'hA7)
      `CHK(coil_b_out, 8'h2A)
   endtask : t_coil
   // signed stall threshold, stall flag, status word and filtered mode
   task t_stall;
      logic [31:0] r;
      wr(lacr_pkg::ADDR_ADAPT, 32'h0);
      wr(lacr_pkg::ADDR_STALL, 32'h0000051F);
      smp(10'h100);
      `CHK(load_readout, 10'h0FB)
      `CHK(stall_out, 1'b0)
      smp(10'h004);
      `CHK(load_readout, 10'h000)
      `CHK(stall_out, 1'b1)
      rd(lacr_pkg::ADDR_STATUS, r);
      `CHK(r, 32'h0019F000)
      rd(lacr_pkg::ADDR_IRQ_STAT, r);
      `CHK(r[3], 1'b1)
      wr(lacr_pkg::ADDR_STALL, 32'h00007D1F);
      smp(10'h100);
      `CHK(load_readout, 10'h103)
      // filtered: no raw response, then a whole window of the new sample
      wr(lacr_pkg::ADDR_STALL, 32'h0001001F);
      smp(10'h080);
      `CHK(load_readout == 10'h080, 1'b0)
      repeat (140) @(posedge clk);
      `CHK(load_readout, 10'h080)
      wr(lacr_pkg::ADDR_STALL, 32'h0000001F);
   endtask : t_stall
   task t_inc;
      logic [4:0] fl;
      wr(lacr_pkg::ADDR_STALL, 32'h0000001F);
      for (int m = 0; m < 2; m++)
      begin
         fl = (m == 0) ? 5'h0F : 5'h07;
         for (int c = 0; c < 4; c++)
         begin
            wr(lacr_pkg::ADDR_ADAPT, 32'h0);
            wr(lacr_pkg::ADDR_ADAPT, adw(m[0], 2'h0, 4'h0, c[1:0], 4'h2));
            `CHK(scale_factor, fl)
            smp(10'h040);
            `CHK(scale_factor, fl)
            smp(10'h03F);
            `CHK(scale_factor, fl + (5'h01 << c))
         end
         smp(10'h000);
         `CHK(scale_factor, (m == 0) ? 5'h1F : 5'h17)
         smp(10'h000);
         `CHK(scale_factor, 5'h1F)
      end
   endtask : t_inc
   task t_dec;
      int n;
      logic [9:0] up;
      for (int d = 0; d < 4; d++)
      begin
         n = (d == 0) ? 32 : (d == 1) ? 8 : (d == 2) ? 2 : 1;
         up = 10'((d + 2) * 32);
         wr(lacr_pkg::ADDR_ADAPT, 32'h0);
         wr(lacr_pkg::ADDR_ADAPT, adw(1'b0, d[1:0], d[3:0], 2'h3, 4'h1));
         smp(10'h000);
         smp(up - 10'h001);
         `CHK(scale_factor, 5'h17)
         repeat (n - 1) smp(up);
         `CHK(scale_factor, 5'h17)
         smp(up);
         `CHK(scale_factor, 5'h16)
      end
      repeat (8) smp(10'h3FF);
      `CHK(scale_factor, 5'h0F)
   endtask : t_dec
   task t_irq;
      logic [31:0] r;
      wr(lacr_pkg::ADDR_ADAPT, 32'h0);
      wr(lacr_pkg::ADDR_ADAPT, adw(1'b0, 2'h0, 4'h0, 2'h0, 4'h2));
      wr(lacr_pkg::ADDR_IRQ_STAT, 32'h0000000F);
      wr(lacr_pkg::ADDR_IRQ_MASK, 32'h00000001);
      smp(10'h000);
      `CHK(irq, 1'b1)
      wr(lacr_pkg::ADDR_IRQ_STAT, 32'h00000001);
      `CHK(irq, 1'b0)
      wr(lacr_pkg::ADDR_IRQ_MASK, 32'h0);
      smp(10'h000);
      `CHK(irq, 1'b0)
      rd(lacr_pkg::ADDR_IRQ_STAT, r);
      `CHK(r[0], 1'b1)
   endtask : t_irq
   // main sequence
   initial
   begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      t_regs;
      t_coil;
      t_stall;
      t_inc;
      t_dec;
      t_irq;
      end_of_test;
   end
   // a hang ends the run as a mismatch
   initial
   begin
      repeat (100000) @(posedge clk);
      fails++;
      end_of_test;
   end
endmodule : lacr_regulator_tb
